// *** include/lir_pkg.sv ***
// Purpose: shared constants for the link id-rom and retry register bank
// Assumes: 32-bit apb data, byte addresses, one 50 MHz core clock
// Notes: offsets are byte addresses of aligned words
`default_nettype none
package lir_pkg;
  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;                      // apb address width
  localparam logic [7:0] OFS_VERSION = 8'h00;     // holds id_rom_present
  localparam logic [7:0] OFS_ROM_ACCESS = 8'h04;  // id_rom_byte_access
  localparam logic [7:0] OFS_RETRY = 8'h08;       // async_transmit_retry_limits
  localparam logic [7:0] OFS_SWAP_DATA = 8'h0c;   // compare_swap_new_value
  localparam logic [7:0] OFS_SWAP_CTRL = 8'h14;   // compare_swap_target_select
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_ROM_PRESENT = 24;   // in version word
  localparam int BIT_ADDR_CLEAR = 31;    // rom_address_clear
  localparam int BIT_READ_GO = 25;       // rom_byte_read_go
  localparam int POS_ROM_VALUE = 16;     // rom_byte_value, bits 23..16
  localparam int POS_REQ_RETRY = 0;      // async_request_retry_max, 3..0
  localparam int POS_RESP_RETRY = 4;     // async_response_retry_max, 7..4
  localparam int POS_PHYS_RETRY = 8;     // phys_response_retry_max, 11..8
  localparam logic [31:0] RETRY_RW_MASK = 32'h0000_0fff; // writable retry bits
  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic [7:0] SMALL_ROM_RESET = 8'h00;   // no small option rom
  localparam logic [11:0] RETRY_RESET = 12'h000;    // all limits zero
  localparam logic [7:0] DL_SMALL_ROM_OFS = 8'h28;  // eeprom word loaded at boot
  localparam logic [1:0] BOOT_SETTLE_CYC = 2'h3;    // wait for presence sync
  // ---------------------------------------------------------------
  // rom access sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    LIR_BOOT = 4'h1,  // settle after reset
    LIR_DL = 4'h2,    // automatic small-rom offset download
    LIR_IDLE = 4'h4,  // waiting for software
    LIR_RD = 4'h8     // software byte read in flight
  } lir_rom_state_t;
endpackage : lir_pkg
`default_nettype wire

// *** core/lir_regs.sv ***
// Purpose: apb bank for id-rom byte access, retry limits and compare-swap data
// Assumes: eeprom engine and transmit units on CORE_CLK; only EE_PRESENT async
// Notes: zero-wait apb slave; unmapped addresses answer with PSLVERR
`default_nettype none
module lir_regs
  import lir_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic EE_PRESENT,
  output logic ROM_RD_REQ,
  output logic [7:0] ROM_RD_ADDR,
  input wire logic ROM_RD_ACK,
  input wire logic [7:0] ROM_RD_DATA,
  input wire logic [2:0] TX_NEW_PACKET,
  input wire logic [2:0] TX_ACK_SEEN,
  input wire logic [2:0] TX_ACK_RETRYABLE,
  output logic [2:0] TX_RESEND,
  output logic [2:0] TX_ABANDON,
  input wire logic CSW_SUCCESS,
  input wire logic [31:0] CSW_NEW_DATA,
  output logic [1:0] CSW_SELECT
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic pres_meta_r;                      // first sync stage only
  logic pres_r;                           // synchronised rom presence
  logic pready_r, pready_nxt;             // apb ready
  logic pslverr_r, pslverr_nxt;           // apb error
  logic [31:0] prdata_r, prdata_nxt;      // apb read data
  lir_rom_state_t st_r, st_nxt;           // rom sequencer
  logic [1:0] boot_r, boot_nxt;           // settle counter
  logic req_r, req_nxt;                   // request to eeprom engine
  logic [7:0] radr_r, radr_nxt;           // byte address sent out
  logic [7:0] rom_addr_r, rom_addr_nxt;   // software byte pointer
  logic clear_r, clear_nxt;               // rom_address_clear
  logic go_r, go_nxt;                     // rom_byte_read_go
  logic [7:0] value_r, value_nxt;         // rom_byte_value
  logic [7:0] small_r, small_nxt;         // small_rom_offset
  logic [11:0] retry_r, retry_nxt;        // three retry limits
  logic [31:0] swap_r, swap_nxt;          // compare_swap_new_value
  logic [1:0] sel_r, sel_nxt;             // compare_swap_target_select
  logic acc, wr;                          // apb access phase and write
  logic [31:0] rom_word;                  // assembled rom access word
  logic sw_rom_wr;                        // software write to the rom access word
  assign acc = PSEL && PENABLE && pready_r;
  assign wr = acc && PWRITE;
  assign sw_rom_wr = wr && PADDR == OFS_ROM_ACCESS;
  // every check below runs on the core clock and sleeps through reset
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // ---------------------------------------------------------------
  // presence synchroniser
  // ---------------------------------------------------------------
  // two flops: the strap pin is not on CORE_CLK
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pres_meta_r <= 1'b0;
      pres_r <= 1'b0;
    end else begin
      pres_meta_r <= EE_PRESENT;
      pres_r <= pres_meta_r;
    end
  end
  assign rom_word = pres_r ? {clear_r, 5'h00, go_r, 1'b0, value_r, 8'h00, small_r} : 32'h0;
  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  // read data is fetched in the setup cycle so every output is a flop
  always_comb begin
    pready_nxt = PSEL && !PENABLE;
    pslverr_nxt = pslverr_r;
    prdata_nxt = prdata_r;
    if (PSEL && !PENABLE) begin
      pslverr_nxt = 1'b0;
      prdata_nxt = 32'h0;
      case (PADDR)
        OFS_VERSION: prdata_nxt[BIT_ROM_PRESENT] = pres_r;
        OFS_ROM_ACCESS: prdata_nxt = rom_word;
        OFS_RETRY: prdata_nxt = {20'h0, retry_r};
        OFS_SWAP_DATA: prdata_nxt = swap_r;
        OFS_SWAP_CTRL: prdata_nxt = {30'h0, sel_r};
        default: pslverr_nxt = 1'b1;   // unmapped word
      endcase
    end else if (acc) begin
      pslverr_nxt = 1'b0;
    end
  end
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end
  // ---------------------------------------------------------------
  // rom access sequencer
  // ---------------------------------------------------------------
  // hardware clears first, software sets after, so a set is never lost
  always_comb begin
    st_nxt = st_r;
    boot_nxt = boot_r;
    req_nxt = req_r;
    radr_nxt = radr_r;
    rom_addr_nxt = rom_addr_r;
    clear_nxt = clear_r;
    go_nxt = go_r;
    value_nxt = value_r;
    small_nxt = small_r;
    case (st_r)
      LIR_BOOT: begin
        if (boot_r != BOOT_SETTLE_CYC) begin
          boot_nxt = boot_r + 2'h1;
        end else if (pres_r) begin
          st_nxt = LIR_DL;
          req_nxt = 1'b1;
          radr_nxt = DL_SMALL_ROM_OFS;
        end else begin
          st_nxt = LIR_IDLE;   // no eeprom: offset stays at reset value
        end
      end
      LIR_DL: begin
        if (ROM_RD_ACK) begin
          req_nxt = 1'b0;
          small_nxt = ROM_RD_DATA;
          st_nxt = LIR_IDLE;
        end
      end
      LIR_IDLE: begin
        if (clear_r) begin
          rom_addr_nxt = 8'h00;
          clear_nxt = 1'b0;
        end else if (go_r) begin
          req_nxt = 1'b1;
          radr_nxt = rom_addr_r;
          st_nxt = LIR_RD;
        end
      end
      LIR_RD: begin
        if (ROM_RD_ACK) begin
          req_nxt = 1'b0;
          value_nxt = ROM_RD_DATA;
          go_nxt = 1'b0;
          rom_addr_nxt = rom_addr_r + 8'h01;   // walk the rom bytewise
          st_nxt = LIR_IDLE;
        end
      end
      default: st_nxt = LIR_BOOT;
    endcase
    if (wr && PADDR == OFS_ROM_ACCESS && pres_r) begin
      if (PWDATA[BIT_ADDR_CLEAR]) begin
        clear_nxt = 1'b1;
      end
      if (PWDATA[BIT_READ_GO]) begin
        go_nxt = 1'b1;
      end
    end
  end
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= LIR_BOOT;
      boot_r <= 2'h0;
      req_r <= 1'b0;
      radr_r <= 8'h00;
      rom_addr_r <= 8'h00;
      clear_r <= 1'b0;
      go_r <= 1'b0;
      value_r <= 8'h00;
      small_r <= SMALL_ROM_RESET;
    end else begin
      st_r <= st_nxt;
      boot_r <= boot_nxt;
      req_r <= req_nxt;
      radr_r <= radr_nxt;
      rom_addr_r <= rom_addr_nxt;
      clear_r <= clear_nxt;
      go_r <= go_nxt;
      value_r <= value_nxt;
      small_r <= small_nxt;
    end
  end
  // ---------------------------------------------------------------
  // retry limits, compare-swap data and selector
  // ---------------------------------------------------------------
  always_comb begin
    retry_nxt = retry_r;
    swap_nxt = swap_r;
    sel_nxt = sel_r;
    if (wr && PADDR == OFS_RETRY) begin
      retry_nxt = PWDATA[11:0];
    end
    if (wr && PADDR == OFS_SWAP_CTRL) begin
      sel_nxt = PWDATA[1:0];
    end
    if (CSW_SUCCESS) begin
      swap_nxt = CSW_NEW_DATA;
    end
  end
  // swap word needs no particular reset value; zero keeps x out of sims
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      retry_r <= RETRY_RESET;
      swap_r <= 32'h0;
      sel_r <= 2'h0;
    end else begin
      retry_r <= retry_nxt;
      swap_r <= swap_nxt;
      sel_r <= sel_nxt;
    end
  end
  // ---------------------------------------------------------------
  // per-unit retry counters: 0 request, 1 async response, 2 physical
  // ---------------------------------------------------------------
  logic [2:0] resend_r, abandon_r;
  generate
    for (genvar u = 0; u < 3; u++) begin : g_unit
      logic [3:0] cnt_r, cnt_nxt;    // retries spent on this packet
      logic [3:0] lim;               // programmed limit
      logic rs_nxt, ab_nxt;
      assign lim = retry_r[u*4 +: 4];
      always_comb begin
        cnt_nxt = cnt_r;
        rs_nxt = 1'b0;
        ab_nxt = 1'b0;
        if (TX_NEW_PACKET[u]) begin
          cnt_nxt = 4'h0;
        end else if (TX_ACK_SEEN[u] && TX_ACK_RETRYABLE[u]) begin
          if (cnt_r < lim) begin
            cnt_nxt = cnt_r + 4'h1;
            rs_nxt = 1'b1;
          end else begin
            ab_nxt = 1'b1;   // limit spent: report failure upward
          end
        end
      end
      always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
          cnt_r <= 4'h0;
          resend_r[u] <= 1'b0;
          abandon_r[u] <= 1'b0;
        end else begin
          cnt_r <= cnt_nxt;
          resend_r[u] <= rs_nxt;
          abandon_r[u] <= ab_nxt;
        end
      end
      retry_under_a: assert property (TX_ACK_SEEN[u] && TX_ACK_RETRYABLE[u] &&
          !TX_NEW_PACKET[u] && cnt_r < lim |=> TX_RESEND[u] && !TX_ABANDON[u])
        else $error("retry not issued under limit");
      retry_spent_a: assert property (TX_ACK_SEEN[u] && TX_ACK_RETRYABLE[u] &&
          !TX_NEW_PACKET[u] && cnt_r == lim |=> TX_ABANDON[u] && !TX_RESEND[u])
        else $error("packet not abandoned at limit");
    end
  endgenerate
  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign ROM_RD_REQ = req_r;
  assign ROM_RD_ADDR = radr_r;
  assign TX_RESEND = resend_r;
  assign TX_ABANDON = abandon_r;
  assign CSW_SELECT = sel_r;
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  clear_done_a: assert property (clear_r && st_r == LIR_IDLE && !sw_rom_wr |=>
      rom_addr_r == 8'h00 && !clear_r) else $error("address clear did not complete");
  clear_nofetch_a: assert property (clear_r && st_r == LIR_IDLE |=>
      $stable(value_r) && !ROM_RD_REQ) else $error("address clear fetched a byte");
  go_clears_a: assert property (st_r == LIR_RD && ROM_RD_ACK && !sw_rom_wr |=>
      !go_r && !ROM_RD_REQ) else $error("read go not cleared after read");
  value_load_a: assert property (st_r == LIR_RD && ROM_RD_ACK |=>
      value_r == $past(ROM_RD_DATA)) else $error("rom byte not captured");
  rom_rsvd_a: assert property (PREADY && PSEL && PENABLE && !PWRITE &&
      PADDR == OFS_ROM_ACCESS |-> (PRDATA & 32'h7d00_ff00) == 32'h0)
    else $error("reserved rom access bits nonzero");
  download_a: assert property (st_r == LIR_DL && ROM_RD_ACK |=>
      small_r == $past(ROM_RD_DATA) && !ROM_RD_REQ) else $error("small offset not loaded");
  retry_rsvd_a: assert property (PREADY && PSEL && PENABLE && !PWRITE &&
      PADDR == OFS_RETRY |-> PRDATA[31:12] == 20'h0) else $error("retry reserved bits nonzero");
  swap_load_a: assert property (CSW_SUCCESS |=>
      swap_r == $past(CSW_NEW_DATA)) else $error("swap value not captured");
  absent_zero_a: assert property (!pres_r && PSEL && !PENABLE &&
      PADDR == OFS_ROM_ACCESS |=> PRDATA == 32'h0) else $error("rom access visible without rom");
  select_wr_a: assert property (wr && PADDR == OFS_SWAP_CTRL |=>
      CSW_SELECT == $past(PWDATA[1:0])) else $error("target select not written");
  cover_clear_c: cover property (clear_r ##1 !clear_r);
  cover_read_c: cover property (st_r == LIR_RD && ROM_RD_ACK);
  cover_dl_c: cover property (st_r == LIR_DL && ROM_RD_ACK);
  cover_abandon_c: cover property (|TX_ABANDON);
endmodule : lir_regs
`default_nettype wire

// *** sim/lir_ee_model.sv ***
// Purpose: eeprom responder facing the rom byte engine
// Assumes: shares CORE_CLK with the register bank
// Notes: answers after 1 or 5 cycles; data toggles whenever not answering
`default_nettype none
module lir_ee_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic rd_req,
  input wire logic [7:0] rd_addr,
  output logic rd_ack,
  output logic [7:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_r; // cycles spent on the open request
  // -------------------------------------------------------------
  // contents
  // -------------------------------------------------------------
  // offset word at 28h
  function automatic logic [7:0] lir_byte(input logic [7:0] a);
    return (a == 8'h28) ? 8'h4b : (a ^ 8'ha5);
  endfunction : lir_byte
  // -------------------------------------------------------------
  // responder
  // -------------------------------------------------------------
  // toggling idle data keeps a late sample from matching by luck
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 3'h0;
      rd_ack <= 1'b0;
      rd_data <= 8'h00;
    end else if (rd_ack || !rd_req) begin
      wait_r <= 3'h0;
      rd_ack <= 1'b0;
      rd_data <= ~rd_data;
    end else if (wait_r == (slow ? 3'h4 : 3'h0)) begin
      rd_ack <= 1'b1;
      rd_data <= lir_byte(rd_addr);
    end else begin
      wait_r <= wait_r + 3'h1;
      rd_data <= ~rd_data;
    end
  end
endmodule : lir_ee_model
`default_nettype wire

// *** sim/link_id_rom_and_retry_regs_tb.sv ***
// Purpose: register-level bench of the id-rom and retry bank
// Assumes: zero-wait apb slave, eeprom model on the rom port
// Notes: transmit units are played by the bench tasks
`default_nettype none
module link_id_rom_and_retry_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lir_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, raddr, rdat;
  logic [31:0] pwdata = 32'h0, csw_data = 32'h0, prdata, rd_r;
  logic pready, pslverr, err_r, req, ack, ee_present = 1'b0, slow = 1'b0, csw_ok = 1'b0;
  logic [2:0] txn = 3'h0, txa = 3'h0, txr = 3'h0, resend, abandon;
  logic [1:0] sel;
  int err_total = 0, cmp_count = 0;
  always #10 clk = ~clk;
  lir_regs u_dut (.CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .EE_PRESENT(ee_present), .ROM_RD_REQ(req), .ROM_RD_ADDR(raddr),
    .ROM_RD_ACK(ack), .ROM_RD_DATA(rdat), .TX_NEW_PACKET(txn), .TX_ACK_SEEN(txa),
    .TX_ACK_RETRYABLE(txr), .TX_RESEND(resend), .TX_ABANDON(abandon),
    .CSW_SUCCESS(csw_ok), .CSW_NEW_DATA(csw_data), .CSW_SELECT(sel));
  lir_ee_model u_ee (.clk(clk), .rst_n(rst_n), .slow(slow), .rd_req(req), .rd_addr(raddr),
    .rd_ack(ack), .rd_data(rdat));
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; answer taken at the edge that sees pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      stop_test();
    end else begin
      rd_r = prdata;
      err_r = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_r & m, exp);
  endtask : rd
  // bounded poll until masked bits match
  task automatic poll(input logic [31:0] m, input logic [31:0] exp);
    for (int i = 0; i < 40; i++) begin
      apb(1'b0, OFS_ROM_ACCESS, 32'h0);
      if ((rd_r & m) === exp) return;
    end
    err_total++;
    stop_test();
  endtask : poll
  task automatic new_pkt(input int u);
    @(posedge clk);
    txn[u] <= 1'b1;
    @(posedge clk);
    txn[u] <= 1'b0;
  endtask : new_pkt
  // ack pulse, then the one-cycle answer is looked at
  task automatic tx_try(input int u, input logic r, input logic rs, input logic ab);
    @(posedge clk);
    txa[u] <= 1'b1;
    txr[u] <= r;
    @(posedge clk);
    txa[u] <= 1'b0;
    // the answer stands for the whole cycle after the ack edge
    @(posedge clk);
    chk({30'h0, resend[u], abandon[u]}, {30'h0, rs, ab});
  endtask : tx_try
  task automatic do_reset(input logic present);
    @(posedge clk);
    rst_n <= 1'b0;
    ee_present <= present;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
  endtask : do_reset
  function automatic logic [31:0] rom_word(input logic [7:0] b);
    return {8'h00, b, 8'h00, 8'h4b};
  endfunction : rom_word
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    do_reset(1'b0);
    rd(OFS_VERSION, 32'h0100_0000, 32'h0);
    rd(OFS_ROM_ACCESS, 32'hffff_ffff, 32'h0);
    rd(OFS_RETRY, 32'hffff_ffff, 32'h0);
    // a slow eeprom keeps the download open while the reset offset is read
    slow <= 1'b1;
    do_reset(1'b1);
    repeat (3) @(posedge clk);
    rd(OFS_ROM_ACCESS, 32'hffff_ffff, 32'h0);
    poll(32'h0000_00ff, 32'h0000_004b);
    rd(OFS_VERSION, 32'h0100_0000, 32'h0100_0000);
    rd(OFS_ROM_ACCESS, 32'hffff_ffff, 32'h0000_004b);
    apb(1'b1, OFS_ROM_ACCESS, 32'h8000_0000);
    poll(32'h8000_0000, 32'h0);
    chk(rd_r, 32'h0000_004b);
    for (int i = 0; i < 3; i++) begin
      slow <= i[0];
      apb(1'b1, OFS_ROM_ACCESS, 32'h0200_0000);
      poll(32'h0200_0000, 32'h0);
      chk(rd_r, rom_word(u_ee.lir_byte(i[7:0])));
    end
    // read-only bits ignore writes
    apb(1'b1, OFS_ROM_ACCESS, 32'h7dff_ffff);
    rd(OFS_ROM_ACCESS, 32'hffff_ffff, rom_word(u_ee.lir_byte(8'h02)));
    // clear and go together: clear first, so byte zero comes back
    apb(1'b1, OFS_ROM_ACCESS, 32'h8200_0000);
    poll(32'h8200_0000, 32'h0);
    chk(rd_r, rom_word(u_ee.lir_byte(8'h00)));
    apb(1'b1, OFS_RETRY, 32'hffff_ffff);
    rd(OFS_RETRY, 32'hffff_ffff, 32'h0000_0fff);
    apb(1'b1, OFS_RETRY, 32'h0000_0210);
    rd(OFS_RETRY, 32'hffff_ffff, 32'h0000_0210);
    // unit u has limit u: u resends, then abandon
    for (int u = 0; u < 3; u++) begin
      new_pkt(u);
      for (int k = 0; k < u; k++) tx_try(u, 1'b1, 1'b1, 1'b0);
      tx_try(u, 1'b1, 1'b0, 1'b1);
    end
    new_pkt(2);
    tx_try(2, 1'b0, 1'b0, 1'b0);
    tx_try(2, 1'b1, 1'b1, 1'b0);
    @(posedge clk);
    csw_ok <= 1'b1;
    csw_data <= 32'h1234_5678;
    @(posedge clk);
    csw_ok <= 1'b0;
    rd(OFS_SWAP_DATA, 32'hffff_ffff, 32'h1234_5678);
    apb(1'b1, OFS_SWAP_DATA, 32'hffff_0000);
    rd(OFS_SWAP_DATA, 32'hffff_ffff, 32'h1234_5678);
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, OFS_SWAP_CTRL, 32'(s));
      rd(OFS_SWAP_CTRL, 32'h3, 32'(s));
      chk({30'h0, sel}, 32'(s));
    end
    // unmapped word answers with an error and zero data
    apb(1'b0, 8'h20, 32'h0);
    chk({err_r, rd_r[30:0]}, 32'h8000_0000);
    stop_test();
  end
endmodule : link_id_rom_and_retry_regs_tb
`default_nettype wire
